//--- verilog/tx_template_pkg.sv
// Constants of the transmit pulse template access block.
// Assumes an 8-bit register port with byte offsets on a single clock.
package tx_template_pkg;
  localparam logic [7:0] OFS_SCALING = 8'h04;
  localparam logic [7:0] OFS_CMD     = 8'h05;
  localparam logic [7:0] OFS_DATA    = 8'h06;
  localparam logic [7:0] OFS_CONFIG1 = 8'h03;

  localparam logic [5:0] SCALE_RESET = 6'h21;
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [6:0] DATA_RESET  = 7'h00;
  localparam logic [3:0] SELECT_RESET = 4'h0;
  // Driver high-impedance bit comes up set, so config one reads 0x10 after reset
  localparam logic [1:0] CFG_HI_RESET = 2'b01;

  localparam int CMD_GO_BIT  = 7;
  localparam int CMD_DIR_BIT = 6;
  localparam int UI_LSB      = 4;
  localparam int SAMP_LSB    = 0;

  // Nominal scaling values per line type
  localparam logic [5:0] SCALE_T1_SHORT = 6'h36;
  localparam logic [5:0] SCALE_DS1_M75  = 6'h11;
  localparam logic [5:0] SCALE_DS1_M150 = 6'h08;
  localparam logic [5:0] SCALE_DS1_M225 = 6'h04;
  localparam logic [5:0] SCALE_E1       = 6'h21;

  localparam logic [1:0] SELECT_USER = 2'b11;
  localparam logic [3:0] SELECT_E1_75_INT = 4'h0;
  localparam logic [3:0] SELECT_E1_75_EXT = 4'h1;
endpackage : tx_template_pkg

//--- verilog/template_ram.sv
// Pulse template storage: 64 samples of 7-bit amplitude in flip-flops.
// Assumes one write or one read per cycle from the register bank.
`timescale 1ns/100ps
module template_ram #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 7,
  parameter int AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  input  wire logic [AW-1:0]    play_addr,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [WIDTH-1:0] play_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data   = mem_q[rd_addr];
  assign play_data = mem_q[play_addr];
endmodule : template_ram

//--- verilog/tx_pulse_template_access.sv
// Transmit pulse template register bank: scaling, indirect RAM access.
// Assumes a synchronous 8-bit register port on CLK, one access per cycle.
//
// Operation
// - A six-bit amplitude scale resets to 100001 and scales user pulses.
// - Nominal scale for T1 short haul, J1 and DS1 0 dB is 110110, 2% a step.
// - Nominal scale for DS1 -7.5 dB is 010001, 6.25% a step.
// - Nominal scale for DS1 -15 dB is 001000, 12.5% a step.
// - Nominal scale for DS1 -22.5 dB is 000100, 25% a step.
// - Nominal scale for E1 75 or 120 ohm is 100001, 3% a step.
// - Writing one to command bit 7 launches one indirect template access.
// - Command bit 6 picks direction: 0 writes the RAM, 1 reads it.
// - Command bits 5-4 pick one of four unit intervals, 00 leftmost.
// - Command bits 3-0 pick one of 16 samples, 0000 leftmost.
// - An indirect write stores the seven-bit data register into the RAM.
// - An indirect read loads the addressed amplitude into the data register.
`timescale 1ns/100ps
module tx_pulse_template_access
  import tx_template_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic [5:0] PLAY_ADDR,
  output logic      [7:0] REG_RDATA,
  output logic            BUSY,
  output logic      [3:0] TEMPLATE_SELECT,
  output logic      [5:0] AMPLITUDE_SCALE,
  output logic            USER_WAVE,
  output logic      [6:0] SHAPE_SAMPLE
);
  typedef enum logic [1:0] {IDLE, ACCESS} acc_state_t;

  logic [5:0] scale_q;
  logic [7:0] cmd_q;
  logic [6:0] data_q;
  logic [3:0] select_q;
  logic [1:0] cfg_hi_q;
  acc_state_t state_q;
  logic       ram_we;
  logic [6:0] ram_rd;
  logic [6:0] ram_play;
  logic [5:0] acc_addr;

  // Offset decode is shared by the write, read and launch paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Scale and waveform select registers

  always_ff @(posedge CLK) begin
    if (RST) begin
      scale_q <= SCALE_RESET;
    end else if (REG_WR && hit(REG_ADDR, OFS_SCALING)) begin
      scale_q <= REG_WDATA[5:0];
    end
  end

  // Nominal values for each line type (SCALE_T1_SHORT etc.) are software's
  // choice; the block scales by whatever is written.
  always_ff @(posedge CLK) begin
    if (RST) begin
      select_q <= SELECT_RESET;
      cfg_hi_q <= CFG_HI_RESET;
    end else if (REG_WR && hit(REG_ADDR, OFS_CONFIG1)) begin
      select_q <= REG_WDATA[3:0];
      cfg_hi_q <= REG_WDATA[5:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect access

  assign acc_addr = {cmd_q[UI_LSB+:2], cmd_q[SAMP_LSB+:4]};
  assign ram_we   = (state_q == ACCESS) && !cmd_q[CMD_DIR_BIT];

  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_q   <= CMD_RESET;
      state_q <= IDLE;
    end else begin
      case (state_q)
        IDLE: begin
          if (REG_WR && hit(REG_ADDR, OFS_CMD)) begin
            cmd_q <= REG_WDATA;
            if (REG_WDATA[CMD_GO_BIT]) begin
              state_q <= ACCESS;
            end
          end
        end
        ACCESS: begin
          // Command writes landing here are dropped; software waits out BUSY
          // Go bit self-clears so the done bit reads low once finished
          cmd_q[CMD_GO_BIT] <= 1'b0;
          state_q           <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      data_q <= DATA_RESET;
      // A completing read wins over a data write in the same cycle
    end else if (state_q == ACCESS && cmd_q[CMD_DIR_BIT]) begin
      data_q <= ram_rd;
    end else if (REG_WR && hit(REG_ADDR, OFS_DATA)) begin
      data_q <= REG_WDATA[6:0];
    end
  end

  template_ram #(
    .DEPTH (64),
    .WIDTH (7),
    .AW    (6)
  ) u_ram (
    .clk       (CLK),
    .rst       (RST),
    .wr_en     (ram_we),
    .wr_addr   (acc_addr),
    .wr_data   (data_q),
    .rd_addr   (acc_addr),
    .play_addr (PLAY_ADDR),
    .rd_data   (ram_rd),
    .play_data (ram_play)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Unmapped offsets read zero so a stray read never returns stale data

  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD && hit(REG_ADDR, OFS_SCALING)) begin
      REG_RDATA <= {2'b00, scale_q};
    end else if (REG_RD && hit(REG_ADDR, OFS_CMD)) begin
      REG_RDATA <= cmd_q;
    end else if (REG_RD && hit(REG_ADDR, OFS_DATA)) begin
      REG_RDATA <= {1'b0, data_q};
    end else if (REG_RD && hit(REG_ADDR, OFS_CONFIG1)) begin
      REG_RDATA <= {2'b00, cfg_hi_q, select_q};
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // Shaper sees the template only under the user waveform setting; others
  // get zero so a stale template can never leak onto a fixed shape.
  always_ff @(posedge CLK) begin
    if (RST) begin
      BUSY            <= 1'b0;
      TEMPLATE_SELECT <= SELECT_RESET;
      AMPLITUDE_SCALE <= SCALE_RESET;
      USER_WAVE       <= 1'b0;
      SHAPE_SAMPLE    <= 7'h00;
    end else begin
      // BUSY mirrors the one access cycle; a refused command cannot raise it
      BUSY            <= (REG_WR && hit(REG_ADDR, OFS_CMD) && REG_WDATA[CMD_GO_BIT]
                          && state_q == IDLE);
      TEMPLATE_SELECT <= select_q;
      AMPLITUDE_SCALE <= scale_q;
      USER_WAVE       <= (select_q[3:2] == SELECT_USER);
      SHAPE_SAMPLE    <= (select_q[3:2] == SELECT_USER) ? ram_play : 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Reset edges are excluded except for the reset-value check, which looks
  // at the first edge after release.

  chk_scale_reset: assert property (@(posedge CLK) $fell(RST) |-> scale_q == 6'h21)
    else $error("scale not at reset value");
  chk_go_launch: assert property (@(posedge CLK) disable iff (RST)
    (state_q == IDLE && REG_WR && REG_ADDR == 8'h05 && REG_WDATA[7]) |=> state_q == ACCESS)
    else $error("access not launched");
  chk_access_ends: assert property (@(posedge CLK) disable iff (RST)
    state_q == ACCESS |=> state_q == IDLE && !cmd_q[7])
    else $error("access did not finish");
  chk_write_dir: assert property (@(posedge CLK) disable iff (RST)
    ram_we |-> state_q == ACCESS && !cmd_q[6])
    else $error("write in wrong direction");
  chk_write_store: assert property (@(posedge CLK) disable iff (RST)
    ram_we |=> u_ram.mem_q[$past(acc_addr)] == $past(data_q))
    else $error("write not stored");
  chk_read_load: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ACCESS && cmd_q[6]) |=> data_q == $past(ram_rd))
    else $error("read data not loaded");
  chk_addr_map: assert property (@(posedge CLK) disable iff (RST)
    acc_addr == 6'(cmd_q[5:4]) * 6'd16 + 6'(cmd_q[3:0]))
    else $error("address mapping wrong");
  chk_user_gate: assert property (@(posedge CLK) disable iff (RST)
    $past(select_q[3:2]) != 2'b11 |-> SHAPE_SAMPLE == 7'h00)
    else $error("template leaked outside user mode");
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
    $past(REG_RD && REG_ADDR == 8'h06) |-> !REG_RDATA[7])
    else $error("reserved bit nonzero");
  chk_busy_access: assert property (@(posedge CLK) disable iff (RST)
    BUSY == (state_q == ACCESS))
    else $error("busy flag does not match access");
  chk_scale_write: assert property (@(posedge CLK) disable iff (RST)
    (REG_WR && REG_ADDR == 8'h04) |=> scale_q == $past(REG_WDATA[5:0]))
    else $error("scale write not taken");
  chk_scale_out: assert property (@(posedge CLK) disable iff (RST)
    AMPLITUDE_SCALE == $past(scale_q))
    else $error("scale output does not follow register");
  chk_scale_reserved: assert property (@(posedge CLK) disable iff (RST)
    $past(REG_RD && REG_ADDR == 8'h04) |-> REG_RDATA[7:6] == 2'b00)
    else $error("scale reserved bits nonzero");
  chk_user_flag: assert property (@(posedge CLK) disable iff (RST)
    USER_WAVE == ($past(select_q[3:2]) == 2'b11))
    else $error("user waveform flag wrong");
  chk_user_play: assert property (@(posedge CLK) disable iff (RST)
    $past(select_q[3:2]) == 2'b11 |-> SHAPE_SAMPLE == $past(u_ram.mem_q[PLAY_ADDR]))
    else $error("template sample not played");
endmodule : tx_pulse_template_access

//--- dv/tx_pulse_template_access_tb_top.sv
// Self-checking bench for the transmit pulse template register bank.
// Assumes a synchronous register port; inputs move 1 ns after CLK rises.
`timescale 1ns/100ps
module tx_pulse_template_access_tb_top
  import tx_template_pkg::*;
;
  logic       CLK, RST, REG_WR, REG_RD, BUSY, USER_WAVE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [5:0] PLAY_ADDR, AMPLITUDE_SCALE;
  logic [3:0] TEMPLATE_SELECT;
  logic [6:0] SHAPE_SAMPLE;
  int         fails, samples_checked;
  tx_pulse_template_access u_dut (
    .CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .PLAY_ADDR(PLAY_ADDR), .REG_RDATA(REG_RDATA), .BUSY(BUSY),
    .TEMPLATE_SELECT(TEMPLATE_SELECT), .AMPLITUDE_SCALE(AMPLITUDE_SCALE),
    .USER_WAVE(USER_WAVE), .SHAPE_SAMPLE(SHAPE_SAMPLE));
  initial CLK = 1'b0;
  always #2 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle
  // Each access holds its strobe for one edge, then lets one idle edge pass so
  // the next call never raises a strobe in the step that lowered it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    idle(1);
    REG_WR    = 1'b0;
    idle(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    idle(1);
    REG_RD   = 1'b0;
    chk(REG_RDATA, exp);
    idle(1);
  endtask : rd
  // Launching command write; BUSY stands for the one access cycle only
  task automatic launch(input logic [7:0] cmd);
    REG_WR    = 1'b1;
    REG_ADDR  = OFS_CMD;
    REG_WDATA = cmd;
    idle(1);
    REG_WR    = 1'b0;
    chk({7'h0, BUSY}, 8'h01);
    idle(1);
    chk({7'h0, BUSY}, 8'h00);
  endtask : launch
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({2'h0, AMPLITUDE_SCALE}, 8'h21);
    rd(OFS_SCALING, 8'h21);
    rd(OFS_CMD, 8'h00);
    rd(OFS_DATA, 8'h00);
    rd(8'h7e, 8'h00);
    rd(OFS_CONFIG1, 8'h10);
  endtask : t_reset
  task automatic t_scale;
    logic [5:0] nom [5];
    nom = '{6'h36, 6'h11, 6'h08, 6'h04, 6'h21};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_SCALING, {2'h0, nom[i]});
      idle(1);
      chk({2'h0, AMPLITUDE_SCALE}, {2'h0, nom[i]});
      rd(OFS_SCALING, {2'h0, nom[i]});
    end
  endtask : t_scale
  task automatic t_reserved;
    wr(OFS_SCALING, 8'hff);
    rd(OFS_SCALING, 8'h3f);
    wr(OFS_DATA, 8'hff);
    rd(OFS_DATA, 8'h7f);
  endtask : t_reserved
  // Corner and alternating-bit addresses of interval and sample fields, written first, then read back
  task automatic t_indirect;
    logic [5:0] ad [4];
    ad = '{6'h00, 6'h3f, 6'h15, 6'h2a};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DATA, {1'b0, ad[i] ^ 6'h2c, 1'b1});
      launch({2'b10, ad[i]});
      idle(1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DATA, 8'h00);
      launch({2'b11, ad[i]});
      idle(2);
      rd(OFS_DATA, {1'b0, ad[i] ^ 6'h2c, 1'b1});
      rd(OFS_CMD, {2'b01, ad[i]});
    end
  endtask : t_indirect
  task automatic t_play;
    wr(OFS_SCALING, 8'h21);
    wr(OFS_CONFIG1, 8'h0d);
    PLAY_ADDR = 6'h15;
    idle(2);
    chk({7'h0, USER_WAVE}, 8'h01);
    chk({1'b0, SHAPE_SAMPLE}, {1'b0, 6'h15 ^ 6'h2c, 1'b1});
    chk({4'h0, TEMPLATE_SELECT}, 8'h0d);
    wr(OFS_CONFIG1, {4'h0, SELECT_E1_75_EXT});
    idle(2);
    chk({4'h0, TEMPLATE_SELECT}, 8'h01);
    chk({7'h0, USER_WAVE}, 8'h00);
    chk({1'b0, SHAPE_SAMPLE}, 8'h00);
  endtask : t_play
  // Reset in mid-run must bring back the scale default and clear the data register
  task automatic t_mid_reset;
    wr(OFS_SCALING, 8'h08);
    RST = 1'b1;
    idle(2);
    RST = 1'b0;
    chk({2'h0, AMPLITUDE_SCALE}, {2'h0, SCALE_RESET});
    rd(OFS_SCALING, {2'h0, SCALE_RESET});
    rd(OFS_DATA, 8'h00);
  endtask : t_mid_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    fails           = 0;
    samples_checked = 0;
    RST             = 1'b1;
    REG_WR          = 1'b0;
    REG_RD          = 1'b0;
    REG_ADDR        = 8'h00;
    REG_WDATA       = 8'h00;
    PLAY_ADDR       = 6'h00;
    idle(6);
    RST = 1'b0;
    t_reset();
    t_scale();
    t_reserved();
    t_indirect();
    t_play();
    t_mid_reset();
    wrap_up();
  end
endmodule : tx_pulse_template_access_tb_top
